// ### rtl/cmpic_defs.vh
// Constants for the comparator interrupt control block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef CMPIC_DEFS_VH
`define CMPIC_DEFS_VH

`define CMPIC_ADDR_CTRL 12'h000
`define CMPIC_ADDR_VREF 12'h004
`define CMPIC_ADDR_FLAG 12'h008
`define CMPIC_ADDR_PEN 12'h00c
`define CMPIC_ADDR_ICTL 12'h010
`define CMPIC_ADDR_EVST 12'h014
`define CMPIC_ADDR_EVCLR 12'h018
`define CMPIC_ADDR_EVEN 12'h01c
`define CMPIC_ADDR_SLEEP 12'h020

`define CMPIC_CTRL_RST 8'h00
`define CMPIC_VREF_RST 8'h00
`define CMPIC_VREF_MASK 8'hef
`define CMPIC_CTRL_WMASK 8'h0f

`define CMPIC_OUT1_BIT 6
`define CMPIC_OUT2_BIT 7
`define CMPIC_CIS_BIT 3
`define CMPIC_FLAG_BIT 6
`define CMPIC_CHGEN_BIT 6
`define CMPIC_PERIPHERAL_IRQ_ENABLE_BIT 6
`define CMPIC_GIE_BIT 7

`define CMPIC_MODE_RESET 3'h0
`define CMPIC_MODE_INTREF 3'h2
`define CMPIC_MODE_OFF 3'h7

`define CMPIC_EV_CHANGE 0
`define CMPIC_EV_WAKE 1
`define CMPIC_EV_W 2

`endif

// ### rtl/cmpic_sync2.v
// Two-flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs come straight from analog comparator outputs.
`timescale 1ns/1ps
module cmpic_sync2 #(
	parameter W = 2
) (
	input wire clk_sys,
	input wire nrst,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_r;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_r <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // cmpic_sync2

// ### rtl/cmpic_top.v
// Digital control of a dual comparator: change flag, enables, sleep wake,
// mode decode and an APB register slave.
// Assumes comparator outputs arrive asynchronously and APB runs on clk_sys.
//
// Behaviour
// - Either output change sets change flag.
// - Outputs readable at control bits 7:6.
// - Flag cleared only by writing zero.
// - Writing one sets flag like hardware.
// - Interrupt needs three enables all set.
// - Flag still sets when interrupt disabled.
// - Change during access may be missed.
// - Control register access relatches outputs.
// - Persisting mismatch keeps setting flag.
// - Detection keeps working during sleep.
// - Enabled change interrupt wakes from sleep.
// - Wake leaves control register unchanged.
// - Reset returns control register to zero.
// - Reset mode makes pins analog inputs.
// - Comparators powered down during reset.
// - Mode 010 routes internal reference.
`timescale 1ns/1ps
`include "cmpic_defs.vh"
module cmpic_top (
	input wire clk_sys,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [1:0] cmpOut,
	input wire sleepReq,
	output reg cmpPowerEn,
	output reg [1:0] cmpAnalogSel,
	output reg intRefSel,
	output reg inputSwitch,
	output reg [7:0] vrefCtrl,
	output reg cmpIrq,
	output reg sleeping,
	output reg wakeUp,
	output reg eventIrq
);
	localparam ST_RUN = 2'b01;
	localparam ST_SLEEP = 2'b10;

	wire [1:0] liveOut;
	reg [1:0] latchOut_r;
	reg [7:0] ctrl_r;
	reg flag_r;
	reg chgEn_r;
	reg peripheral_irq_enable_r;
	reg gie_r;
	reg [1:0] pmState_r;
	reg [`CMPIC_EV_W-1:0] evStat_r;
	reg [`CMPIC_EV_W-1:0] evEn_r;
	reg [31:0] rdData;
	reg addrOk;

	// Only the first access-phase cycle is acted on, so every access has one wait state.
	wire acc = psel & penable & ~pready;
	wire wr = acc & pwrite;
	wire [7:0] wb = pwdata[7:0];

	function hit;
		input [11:0] a;
		input [11:0] b;
		hit = (a == b);
	endfunction

	wire ctrlAcc = acc & hit(paddr, `CMPIC_ADDR_CTRL);
	wire mismatch = (liveOut != latchOut_r);
	wire irqNow = flag_r & chgEn_r & peripheral_irq_enable_r & gie_r;
	wire [2:0] mode = ctrl_r[2:0];

	cmpic_sync2 #(.W(2)) u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(cmpOut),
		.sync_out(liveOut)
	);

	always @* begin
		addrOk = 1'b1;
		rdData = 32'h00000000;
		case (paddr)
		`CMPIC_ADDR_CTRL: rdData[7:0] = {liveOut[1], liveOut[0], ctrl_r[5:0]};
		`CMPIC_ADDR_VREF: rdData[7:0] = vrefCtrl;
		`CMPIC_ADDR_FLAG: rdData[`CMPIC_FLAG_BIT] = flag_r;
		`CMPIC_ADDR_PEN: rdData[`CMPIC_CHGEN_BIT] = chgEn_r;
		`CMPIC_ADDR_ICTL: rdData[7:6] = {gie_r, peripheral_irq_enable_r};
		`CMPIC_ADDR_EVST: rdData[`CMPIC_EV_W-1:0] = evStat_r;
		`CMPIC_ADDR_EVCLR: rdData = 32'h00000000;
		`CMPIC_ADDR_EVEN: rdData[`CMPIC_EV_W-1:0] = evEn_r;
		`CMPIC_ADDR_SLEEP: rdData[0] = sleeping;
		default: addrOk = 1'b0;
		endcase
	end

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc;
			pslverr <= acc & ~addrOk;
			// A refused write loads the zero read word as well, so an
			// error response never carries stale data from an old read.
			if (acc && (!pwrite || !addrOk))
				prdata <= rdData;
		end
	end

	// Register writes, relatch and change flag.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= `CMPIC_CTRL_RST;
			vrefCtrl <= `CMPIC_VREF_RST;
			latchOut_r <= 2'b00;
			flag_r <= 1'b0;
			chgEn_r <= 1'b0;
			peripheral_irq_enable_r <= 1'b0;
			gie_r <= 1'b0;
			evEn_r <= {`CMPIC_EV_W{1'b0}};
		end else begin
			// The relatch takes the same synchronised value the flag sees,
			// so a change coinciding with an access can be lost.
			if (ctrlAcc)
				latchOut_r <= liveOut;
			if (wr && hit(paddr, `CMPIC_ADDR_CTRL))
				ctrl_r <= wb & `CMPIC_CTRL_WMASK;
			if (wr && hit(paddr, `CMPIC_ADDR_VREF))
				vrefCtrl <= wb & `CMPIC_VREF_MASK;
			if (wr && hit(paddr, `CMPIC_ADDR_PEN))
				chgEn_r <= wb[`CMPIC_CHGEN_BIT];
			if (wr && hit(paddr, `CMPIC_ADDR_ICTL)) begin
				peripheral_irq_enable_r <= wb[`CMPIC_PERIPHERAL_IRQ_ENABLE_BIT];
				gie_r <= wb[`CMPIC_GIE_BIT];
			end
			if (wr && hit(paddr, `CMPIC_ADDR_EVEN))
				evEn_r <= wb[`CMPIC_EV_W-1:0];
			// Hardware set wins over a software clear in the same cycle.
			if (mismatch && !ctrlAcc)
				flag_r <= 1'b1;
			else if (wr && hit(paddr, `CMPIC_ADDR_FLAG))
				flag_r <= wb[`CMPIC_FLAG_BIT];
		end
	end

	// Sleep state; waking touches no control state.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pmState_r <= ST_RUN;
			wakeUp <= 1'b0;
		end else begin
			wakeUp <= 1'b0;
			case (pmState_r)
			ST_RUN: if (sleepReq) pmState_r <= ST_SLEEP;
			ST_SLEEP: begin
				// Wake needs only the local enable and peripheral enable path.
				if (flag_r & chgEn_r & peripheral_irq_enable_r) begin
					pmState_r <= ST_RUN;
					wakeUp <= 1'b1;
				end
			end
			default: pmState_r <= ST_RUN;
			endcase
		end
	end

	// Event status with write-one-to-clear; set wins over clear.
	wire [`CMPIC_EV_W-1:0] evSet;
	assign evSet[`CMPIC_EV_CHANGE] = mismatch & ~ctrlAcc;
	assign evSet[`CMPIC_EV_WAKE] = (pmState_r == ST_SLEEP) &
		flag_r & chgEn_r & peripheral_irq_enable_r;
	wire evClrWr = wr & hit(paddr, `CMPIC_ADDR_EVCLR);
	genvar g;
	generate
		for (g = 0; g < `CMPIC_EV_W; g = g + 1) begin : gEv
			always @(posedge clk_sys or negedge nrst) begin
				if (!nrst)
					evStat_r[g] <= 1'b0;
				else if (evSet[g])
					evStat_r[g] <= 1'b1;
				else if (evClrWr && wb[g])
					evStat_r[g] <= 1'b0;
			end
		end
	endgenerate

	// Registered outputs; all but cmpAnalogSel, held at 11, are low while nrst is low.
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmpPowerEn <= 1'b0;
			cmpAnalogSel <= 2'b11;
			intRefSel <= 1'b0;
			inputSwitch <= 1'b0;
			cmpIrq <= 1'b0;
			sleeping <= 1'b0;
			eventIrq <= 1'b0;
		end else begin
			// Power stays on through sleep unless off or reset mode is chosen.
			cmpPowerEn <= (mode != `CMPIC_MODE_OFF) &&
				(mode != `CMPIC_MODE_RESET);
			cmpAnalogSel <= (mode == `CMPIC_MODE_RESET) ? 2'b11 : 2'b00;
			intRefSel <= (mode == `CMPIC_MODE_INTREF);
			inputSwitch <= ctrl_r[`CMPIC_CIS_BIT];
			cmpIrq <= irqNow;
			sleeping <= (pmState_r == ST_SLEEP);
			eventIrq <= |(evStat_r & evEn_r);
		end
	end
endmodule // cmpic_top

// ### tb/cmpic_checker.sv
// Concurrent checks on the ports of the comparator control block.
// Assumes one clock domain and an APB slave with one wait state.
`timescale 1ns/1ps
module cmpic_checker (
	input wire clk_sys,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire cmpPowerEn,
	input wire [1:0] cmpAnalogSel,
	input wire intRefSel,
	input wire cmpIrq,
	input wire sleeping,
	input wire wakeUp
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	sequence waitState;
		psel && penable && !pready;
	endsequence
	sequence answer;
		pready ##1 !pready;
	endsequence
	chk_ready_wait: assert property (waitState |=> answer)
		else $error("no single ready pulse");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("refused access returned data");
	chk_reset_mode: assert property (cmpAnalogSel == 2'b11 |-> !cmpPowerEn)
		else $error("powered in reset mode");
	chk_ref_power: assert property (intRefSel |-> cmpPowerEn)
		else $error("reference routed while off");
	chk_wake_pulse: assert property (wakeUp |=> !wakeUp)
		else $error("wake longer than a cycle");
	chk_wake_irq: assert property (cmpIrq && sleeping |-> ##[0:2] wakeUp)
		else $error("interrupt did not wake");
	chk_wake_leave: assert property (wakeUp |-> ##[0:1] !sleeping)
		else $error("still asleep after wake");
endmodule // cmpic_checker

bind cmpic_top cmpic_checker u_chk (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.cmpPowerEn(cmpPowerEn),
	.cmpAnalogSel(cmpAnalogSel),
	.intRefSel(intRefSel),
	.cmpIrq(cmpIrq),
	.sleeping(sleeping),
	.wakeUp(wakeUp)
);

// ### tb/cmpic_cmp_model.sv
// Behavioural pair of analog comparators seen as two digital outputs.
// Assumes the bench sets the wanted levels; outputs lag unrelated to clock.
`timescale 1ns/1ps
module cmpic_cmp_model (
	input wire [1:0] level,
	output logic [1:0] cmpOut
);
	// The lag keeps output edges away from the clock edge on purpose.
	always @(level) cmpOut <= #7 level;
endmodule // cmpic_cmp_model

// ### tb/cmpic_top_bench.sv
// Self-checking bench for the comparator control block over APB.
// Assumes a 25 MHz clock and one wait state per transfer.
`timescale 1ns/1ps
`include "cmpic_defs.vh"
module cmpic_top_bench;
	logic clk_sys, nrst, psel, penable, pwrite, sleepReq, pready, pslverr;
	logic cmpPowerEn, intRefSel, inputSwitch, cmpIrq, sleeping, wakeUp;
	logic eventIrq, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [1:0] cmpOut, cmpAnalogSel, level;
	logic [7:0] vrefCtrl;
	logic [3:0] md[3] = '{4'h0, 4'h7, 4'ha};
	logic [3:0] ex[3] = '{4'h3, 4'h0, 4'hc};
	int errors, checks;
	cmpic_top dut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.cmpOut(cmpOut),
		.sleepReq(sleepReq),
		.cmpPowerEn(cmpPowerEn),
		.cmpAnalogSel(cmpAnalogSel),
		.intRefSel(intRefSel),
		.inputSwitch(inputSwitch),
		.vrefCtrl(vrefCtrl),
		.cmpIrq(cmpIrq),
		.sleeping(sleeping),
		.wakeUp(wakeUp),
		.eventIrq(eventIrq)
	);
	cmpic_cmp_model cmp (.level(level), .cmpOut(cmpOut));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		tick(3000);
		errors++;
		wrap_up;
	end
	initial begin
		{nrst, psel, penable, pwrite, sleepReq, level} = 0;
		{paddr, pwdata} = 0;
		tick(3);
		nrst <= 1'b1;
		rd(`CMPIC_ADDR_CTRL, 32'h0);
		wr(`CMPIC_ADDR_VREF, 32'hff);
		rd(`CMPIC_ADDR_VREF, 32'hef);
		chk(32'(vrefCtrl), 32'hef);
		rd(12'h0fc, 32'h0);
		chk(32'(perr), 32'h1);
		for (int i = 0; i < 3; i++) begin
			wr(`CMPIC_ADDR_CTRL, 32'(md[i]));
			tick(2);
			chk(32'({intRefSel, cmpPowerEn, cmpAnalogSel}), 32'(ex[i]));
			chk(32'(inputSwitch), 32'(md[i][3]));
		end
		level <= 2'b01;
		tick(5);
		rd(`CMPIC_ADDR_FLAG, 32'h40);
		wr(`CMPIC_ADDR_FLAG, 32'h0);
		rd(`CMPIC_ADDR_FLAG, 32'h40);
		rd(`CMPIC_ADDR_CTRL, 32'h4a);
		wr(`CMPIC_ADDR_FLAG, 32'h0);
		rd(`CMPIC_ADDR_FLAG, 32'h0);
		wr(`CMPIC_ADDR_FLAG, 32'h40);
		rd(`CMPIC_ADDR_FLAG, 32'h40);
		wr(`CMPIC_ADDR_PEN, 32'h40);
		wr(`CMPIC_ADDR_ICTL, 32'h40);
		chk(32'(cmpIrq), 32'h0);
		wr(`CMPIC_ADDR_ICTL, 32'hc0);
		tick(1);
		chk(32'(cmpIrq), 32'h1);
		rd(`CMPIC_ADDR_EVST, 32'h1);
		chk(32'(eventIrq), 32'h0);
		wr(`CMPIC_ADDR_EVEN, 32'h1);
		tick(1);
		chk(32'(eventIrq), 32'h1);
		wr(`CMPIC_ADDR_EVCLR, 32'h1);
		tick(1);
		chk(32'(eventIrq), 32'h0);
		wr(`CMPIC_ADDR_FLAG, 32'h0);
		sleepReq <= 1'b1;
		tick(3);
		chk(32'(sleeping), 32'h1);
		level <= 2'b10;
		for (int i = 0; i < 12 && wakeUp !== 1'b1; i++) @(posedge clk_sys);
		chk(32'(wakeUp), 32'h1);
		sleepReq <= 1'b0;
		tick(2);
		rd(`CMPIC_ADDR_CTRL, 32'h8a);
		nrst <= 1'b0;
		tick(2);
		chk(32'(cmpPowerEn), 32'h0);
		nrst <= 1'b1;
		chk(32'(cmpAnalogSel), 32'h3);
		tick(2);
		rd(`CMPIC_ADDR_CTRL, 32'h80);
		wrap_up;
	end
endmodule // cmpic_top_bench
